//--- inc/pisc_pkg.sv
// register map, field layout and encodings of the input select control
package pisc_pkg;

  localparam logic [7:0] ADDR_BW      = 8'h02;
  localparam logic [7:0] ADDR_SEL     = 8'h03;
  localparam logic [7:0] ADDR_METHOD  = 8'h04;
  localparam logic [7:0] ADDR_DRIVE   = 8'h05;

  localparam logic [7:0] RST_BW       = 8'h42;
  localparam logic [7:0] RST_SEL      = 8'h05;
  localparam logic [7:0] RST_METHOD   = 8'h12;
  localparam logic [7:0] RST_DRIVE    = 8'hed;

  // writable bit masks; the rest hold their reset value
  localparam logic [7:0] WMASK_BW     = 8'hf0;
  localparam logic [7:0] WMASK_SEL    = 8'hf0;
  localparam logic [7:0] WMASK_METHOD = 8'hdf;
  localparam logic [7:0] WMASK_DRIVE  = 8'hc0;

  localparam int BW_MSB      = 7;
  localparam int BW_LSB      = 4;
  localparam int INSEL_MSB   = 7;
  localparam int INSEL_LSB   = 6;
  localparam int HOLD_BIT    = 5;
  localparam int SQUELCH_BIT = 4;
  localparam int METHOD_MSB  = 7;
  localparam int METHOD_LSB  = 6;
  localparam int HIST_MSB    = 4;
  localparam int HIST_LSB    = 0;
  localparam int DRIVE_MSB   = 7;
  localparam int DRIVE_LSB   = 6;

  // input select codes
  localparam logic [1:0] INSEL_ONE   = 2'h0;
  localparam logic [1:0] INSEL_TWO   = 2'h1;

  typedef enum logic [1:0] {
    PISC_MANUAL      = 2'b00,
    PISC_AUTO_NONREV = 2'b01,
    PISC_AUTO_REV    = 2'b10,
    PISC_METHOD_RSVD = 2'b11
  } pisc_method_type;

  typedef enum logic [1:0] {
    PISC_SRC_ONE  = 2'b00,
    PISC_SRC_TWO  = 2'b01,
    PISC_SRC_HOLD = 2'b10
  } pisc_src_type;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pisc_req_type;

  typedef struct packed {
    logic [3:0] loop_bandwidth;
    logic       squelch_out;
    pisc_src_type active_src;
    logic [4:0] history_delay;
    logic [1:0] cmos_drive_strength;
    logic       auto_revertive;
  } pisc_ctrl_type;

endpackage

//--- verilog/pisc_sync.sv
// two-flop synchroniser for a single pin level
module pisc_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule

//--- verilog/pisc_ctrl.sv
// input select, holdover, squelch and drive control registers
module pisc_ctrl
  import pisc_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // serial control port, decoded
  input  wire pisc_pkg::pisc_req_type req,
  output logic [7:0]         rdata,
  output logic               rvalid,
  // pins and device status
  input  wire logic          clock_select_pin,
  input  wire logic          pin_select_enable,
  input  wire logic          output_force_on,
  input  wire logic          cal_start,
  input  wire logic          cal_busy,
  input  wire logic          auto_src_two,
  // controls to the loop and outputs
  output pisc_pkg::pisc_ctrl_type ctrl,
  output logic               clock_output_en
);
  import pisc_pkg::*;

  logic [7:0] bw_ff;
  logic [7:0] sel_ff;
  logic [7:0] method_ff;
  logic [7:0] drive_ff;
  logic [3:0] bw_active_ff;
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic       pin_sync;
  pisc_src_type   nxt_src;
  pisc_method_type method;

  pisc_sync u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (clock_select_pin),
    .dout  (pin_sync)
  );

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] wmask);
    merge = (old_v & ~wmask) | (new_v & wmask);
  endfunction

  // register writes; reserved bits keep their reset value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bw_ff     <= RST_BW;
      sel_ff    <= RST_SEL;
      method_ff <= RST_METHOD;
      drive_ff  <= RST_DRIVE;
    end else if (ce && req.wr_en) begin
      if (req.addr == ADDR_BW) begin
        bw_ff <= merge(bw_ff, req.wdata, WMASK_BW);
      end else if (req.addr == ADDR_SEL) begin
        sel_ff <= merge(sel_ff, req.wdata, WMASK_SEL);
      end else if (req.addr == ADDR_METHOD) begin
        method_ff <= merge(method_ff, req.wdata, WMASK_METHOD);
      end else if (req.addr == ADDR_DRIVE) begin
        drive_ff <= merge(drive_ff, req.wdata, WMASK_DRIVE);
      end
    end
  end

  // loop bandwidth is latched into the loop only at calibration start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bw_active_ff <= RST_BW[BW_MSB:BW_LSB];
    end else if (ce && cal_start) begin
      bw_active_ff <= bw_ff[BW_MSB:BW_LSB];
    end
  end

  // register reads, answered one cycle later; unmapped reads as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else if (ce) begin
      rvalid_ff <= req.rd_en;
      if (req.rd_en) begin
        if (req.addr == ADDR_BW) begin
          rdata_ff <= bw_ff;
        end else if (req.addr == ADDR_SEL) begin
          rdata_ff <= sel_ff;
        end else if (req.addr == ADDR_METHOD) begin
          rdata_ff <= method_ff;
        end else if (req.addr == ADDR_DRIVE) begin
          rdata_ff <= drive_ff;
        end else begin
          rdata_ff <= 8'h00;
        end
      end
    end
  end

  assign rdata  = rdata_ff;
  assign rvalid = rvalid_ff;
  assign method = pisc_method_type'(method_ff[METHOD_MSB:METHOD_LSB]);

  // source choice: hold first, then manual pin or register, then automatic
  always_comb begin
    nxt_src = PISC_SRC_ONE;
    if (sel_ff[HOLD_BIT]) begin
      nxt_src = PISC_SRC_HOLD;
    end else begin
      case (method)
        PISC_MANUAL: begin
          if (pin_select_enable) begin
            nxt_src = pin_sync ? PISC_SRC_TWO : PISC_SRC_ONE;
          end else if (sel_ff[INSEL_MSB:INSEL_LSB] == INSEL_TWO) begin
            nxt_src = PISC_SRC_TWO;
          end else begin
            nxt_src = PISC_SRC_ONE;
          end
        end
        PISC_AUTO_NONREV,
        PISC_AUTO_REV: begin
          nxt_src = auto_src_two ? PISC_SRC_TWO : PISC_SRC_ONE;
        end
        default: begin
          nxt_src = PISC_SRC_ONE;
        end
      endcase
    end
  end

  // control outputs come from flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else if (ce) begin
      ctrl.loop_bandwidth      <= bw_active_ff;
      ctrl.active_src          <= nxt_src;
      ctrl.squelch_out         <= sel_ff[SQUELCH_BIT] && cal_busy
                                  && !output_force_on;
      ctrl.history_delay       <= method_ff[HIST_MSB:HIST_LSB];
      ctrl.cmos_drive_strength <= drive_ff[DRIVE_MSB:DRIVE_LSB];
      ctrl.auto_revertive      <= (method == PISC_AUTO_REV);
    end
  end

  assign clock_output_en = !ctrl.squelch_out;

  // manual selection conditions shared by the selection checks
  sequence seq_manual_reg;
    ce && !sel_ff[HOLD_BIT] && method == PISC_MANUAL && !pin_select_enable;
  endsequence

  sequence seq_manual_pin;
    ce && !sel_ff[HOLD_BIT] && method == PISC_MANUAL && pin_select_enable;
  endsequence

  // hold flag forces the hold source on the next edge
  chk_hold_wins: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && sel_ff[HOLD_BIT] |=> ctrl.active_src == PISC_SRC_HOLD)
    else $error("hold bit did not force holdover");

  chk_squelch_cal: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && sel_ff[SQUELCH_BIT] && cal_busy && !output_force_on
    |=> !clock_output_en)
    else $error("outputs not squelched during calibration");

  chk_no_squelch: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && !(sel_ff[SQUELCH_BIT] && cal_busy) |=> clock_output_en)
    else $error("outputs squelched outside a squelching calibration");

  chk_force_on: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && output_force_on |=> clock_output_en)
    else $error("force-on did not keep outputs enabled");

  chk_bw_waits: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cal_start |=> $stable(bw_active_ff))
    else $error("bandwidth changed without calibration");

  chk_bw_takes: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && cal_start ##1 ce
    |=> ctrl.loop_bandwidth == $past(bw_ff[BW_MSB:BW_LSB], 2))
    else $error("calibration did not apply the written bandwidth");

  chk_reg_manual: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_manual_reg ##0 sel_ff[INSEL_MSB:INSEL_LSB] == INSEL_ONE
    |=> ctrl.active_src == PISC_SRC_ONE)
    else $error("register select one not honoured");

  chk_reg_two: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_manual_reg ##0 sel_ff[INSEL_MSB:INSEL_LSB] == INSEL_TWO
    |=> ctrl.active_src == PISC_SRC_TWO)
    else $error("register select two not honoured");

  chk_pin_manual: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_manual_pin
    |=> ctrl.active_src == ($past(pin_sync) ? PISC_SRC_TWO : PISC_SRC_ONE))
    else $error("pin select not honoured");

  // pin level crosses two synchroniser stages and the control register
  chk_pin_path: assert property (
    @(posedge clk) disable iff (!rst_n)
    seq_manual_pin ##1 seq_manual_pin ##1 seq_manual_pin
    |=> ctrl.active_src
        == ($past(clock_select_pin, 3) ? PISC_SRC_TWO : PISC_SRC_ONE))
    else $error("pin level not followed after synchronising");

  chk_auto_src: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && !sel_ff[HOLD_BIT]
    && (method == PISC_AUTO_NONREV || method == PISC_AUTO_REV)
    |=> ctrl.active_src
        == ($past(auto_src_two) ? PISC_SRC_TWO : PISC_SRC_ONE)
    && ctrl.auto_revertive == ($past(method) == PISC_AUTO_REV))
    else $error("automatic selection not honoured");

  chk_reserved_ro: assert property (
    @(posedge clk) disable iff (!rst_n)
    (bw_ff & ~WMASK_BW) == (RST_BW & ~WMASK_BW)
    && (sel_ff & ~WMASK_SEL) == (RST_SEL & ~WMASK_SEL)
    && (method_ff & ~WMASK_METHOD) == (RST_METHOD & ~WMASK_METHOD)
    && (drive_ff & ~WMASK_DRIVE) == (RST_DRIVE & ~WMASK_DRIVE))
    else $error("reserved bits changed");

  // the release edge still holds ctrl in reset, so it starts no attempt
  chk_hist_drive: assert property (
    @(posedge clk) disable iff (!rst_n)
    rst_n && ce ##1 ce
    |-> ctrl.history_delay == $past(method_ff[HIST_MSB:HIST_LSB])
    && ctrl.cmos_drive_strength == $past(drive_ff[DRIVE_MSB:DRIVE_LSB]))
    else $error("history or drive field not passed on");

  chk_read_rsvd: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && req.rd_en && req.addr == ADDR_BW
    |=> rvalid && (rdata & ~WMASK_BW) == (RST_BW & ~WMASK_BW))
    else $error("reserved bits not read back at reset value");

endmodule

//--- verif/pll_input_select_control_bench.sv
// register-level self-checking bench of the input select control
module pll_input_select_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pisc_pkg::*;

  logic          clk;
  logic          rst_n;
  logic          ce;
  pisc_req_type  req;
  logic [7:0]    rdata;
  logic          rvalid;
  logic          pin;
  logic          pin_en;
  logic          force_on;
  logic          cal_start;
  logic          cal_busy;
  logic          auto_two;
  pisc_ctrl_type ctrl;
  logic          out_en;
  int            num_errors;
  int            total_checks;
  logic [7:0]    addrs [4] = '{ADDR_BW, ADDR_SEL, ADDR_METHOD, ADDR_DRIVE};
  logic [7:0]    rsts  [4] = '{RST_BW, RST_SEL, RST_METHOD, RST_DRIVE};
  logic [7:0]    masks [4] = '{WMASK_BW, WMASK_SEL, WMASK_METHOD, WMASK_DRIVE};
  // selection table: select reg, method reg, {pin_en, pin, auto}, source
  logic [7:0]    sels  [8] = '{8'h00, 8'h40, 8'h40, 8'h00,
                               8'h20, 8'h00, 8'h20, 8'h40};
  logic [7:0]    meths [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h40, 8'h80, 8'h80};
  logic [2:0]    pins  [8] = '{3'h0, 3'h0, 3'h4, 3'h6, 3'h6, 3'h1, 3'h1, 3'h6};
  logic [1:0]    srcs  [8] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h0};

  pisc_ctrl dut_u (
    .clk               (clk),
    .rst_n             (rst_n),
    .ce                (ce),
    .req               (req),
    .rdata             (rdata),
    .rvalid            (rvalid),
    .clock_select_pin  (pin),
    .pin_select_enable (pin_en),
    .output_force_on   (force_on),
    .cal_start         (cal_start),
    .cal_busy          (cal_busy),
    .auto_src_two      (auto_two),
    .ctrl              (ctrl),
    .clock_output_en   (out_en)
  );

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    int n;
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      num_errors++;
      test_done();
    end else begin
      chk(rdata, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    {pin, pin_en, force_on, cal_start, cal_busy, auto_two} = 6'h00;
    num_errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(addrs[i], rsts[i]);
      // 7f sets reserved bits but keeps every field at a defined code
      wr(addrs[i], 8'h7f);
      rd(addrs[i], (rsts[i] & ~masks[i]) | (8'h7f & masks[i]));
      wr(addrs[i], 8'h00);
      rd(addrs[i], rsts[i] & ~masks[i]);
    end
    rd(8'h07, 8'h00);
    $display("test registers done");
    wr(ADDR_BW, 8'ha0);
    tick(4);
    chk(8'(ctrl.loop_bandwidth), 8'h04);
    @(posedge clk);
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    tick(3);
    chk(8'(ctrl.loop_bandwidth), 8'h0a);
    // with the clock enable low, a write and a calibration start are lost
    @(posedge clk);
    ce <= 1'b0;
    wr(ADDR_BW, 8'h50);
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    ce <= 1'b1;
    rd(ADDR_BW, 8'ha2);
    chk(8'(ctrl.loop_bandwidth), 8'h0a);
    $display("test bandwidth done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {pin_en, pin, auto_two} <= pins[i];
      wr(ADDR_SEL, sels[i]);
      wr(ADDR_METHOD, meths[i]);
      tick(4);
      chk(8'(ctrl.active_src), 8'(srcs[i]));
      chk(8'(ctrl.auto_revertive), 8'(meths[i] == 8'h80));
    end
    $display("test selection done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DRIVE, {2'(i), 6'h00});
      wr(ADDR_METHOD, {3'h0, 5'(i * 10 + 1)});
      tick(3);
      chk(8'(ctrl.cmos_drive_strength), 8'(i));
      chk(8'(ctrl.history_delay), 8'(i * 10 + 1));
    end
    $display("test drive and history done");
    @(posedge clk);
    {pin_en, auto_two} <= 2'b00;
    wr(ADDR_SEL, 8'h10);
    tick(3);
    chk(8'(out_en), 8'h01);
    @(posedge clk);
    cal_busy <= 1'b1;
    tick(3);
    chk(8'(out_en), 8'h00);
    @(posedge clk);
    force_on <= 1'b1;
    tick(3);
    chk(8'(out_en), 8'h01);
    @(posedge clk);
    force_on <= 1'b0;
    wr(ADDR_SEL, 8'h00);
    tick(3);
    chk(8'(out_en), 8'h01);
    @(posedge clk);
    cal_busy <= 1'b0;
    $display("test squelch done");
    test_done();
  end
endmodule
